// [src/data_channel_control_regs.sv]
// Directly reached control and status registers of the data channel controllers.
// Assumes requests and channel status are synchronous to core_clk.
`timescale 1ns/1ns
`include "dcc_regs_consts.svh"

// Summary of operation
// RQ1: Reads zero-fill bits above register width
// RQ2: Plain writes keep only implemented bits
// RQ3: Set port ORs written word in
// RQ4: Clear port ANDs inverse of word
// RQ5: Fields are unsigned unless declared otherwise
// RQ6: Fractional fields fixed point, signed two's complement
// RQ7: Run enable bits 13-0, reset zero
// RQ8: Disable waits for ongoing transfer end
// RQ9: Reset command bits reset one channel
// RQ10: Reset command ignored while channel enabled
// RQ11: Interrupt enable register at 0x98
// RQ12: Threshold and drained status read-only
// RQ13: Lost-data and overrun flags read-only
// RQ14: Ring selector and value indirect access
// RQ15: Algorithm selector and value indirect access
// RQ16: Raw source and decimation registers read/write
// RQ17: Parameters accepted only while channel disabled
// RQ18: Enable reads one until really disabled
// RQ19: Overrun wipe bits clear overrun flags
// RQ20: Reserved offsets read zero, ignore writes
module data_channel_control_regs (
   // Clock, reset and enable
   input  wire logic                       core_clk,
   input  wire logic                       rst_n,
   input  wire logic                       ce,
   // Register port
   input  wire dcc_regs_pkg::reg_req_type  req,
   output logic [`DCC_DATA_W-1:0]          rdata,
   output logic                            rvalid,
   // Channel status
   input  wire dcc_regs_pkg::chan_stat_type stat,
   // Channel control
   output logic [`DCC_NUM_CHAN-1:0]        chan_en,
   output logic [`DCC_NUM_CHAN-1:0]        chan_reset,
   output logic [`DCC_DATA_W-1:0]          irq_en,
   // Indirect parameter access
   output logic [`DCC_DATA_W-1:0]          ring_sel,
   output logic [`DCC_DATA_W-1:0]          algo_sel,
   output logic [`DCC_DATA_W-1:0]          param_wdata,
   output logic                            ring_wr,
   output logic                            algo_wr,
   input  wire logic [`DCC_DATA_W-1:0]     ring_rdata,
   input  wire logic [`DCC_DATA_W-1:0]     algo_rdata,
   // Raw data path setup
   output logic [`DCC_DATA_W-1:0]          raw_src,
   output logic [`DCC_DATA_W-1:0]          decim
);
   import dcc_regs_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State and helpers
   state_type                    s_r;          // Registered state
   state_type                    s_nxt;        // Next state
   logic [`DCC_NUM_CHAN-1:0]     wbits;        // Write data at channel width
   logic [`SEL_CHAN_HI-`SEL_CHAN_LO:0] ring_ch; // Channel picked by ring selector
   logic [`SEL_CHAN_HI-`SEL_CHAN_LO:0] algo_ch; // Channel picked by algo selector
   logic                         ring_locked;  // Ring target channel is enabled
   logic                         algo_locked;  // Algo target channel is enabled
   logic                         wr_hit;       // Write taken this cycle
   logic                         rd_hit;       // Read taken this cycle

   // Applies write, set or clear to a 32-bit word
   function automatic logic [`DCC_DATA_W-1:0] apply32(
      input logic [`DCC_DATA_W-1:0] old,
      input logic [`DCC_DATA_W-1:0] wd,
      input access_type             acc);
      unique case (acc)
         ACC_SET:   apply32 = old | wd;    // see RQ3
         ACC_CLEAR: apply32 = old & ~wd;   // see RQ4
         default:   apply32 = wd;          // see RQ2 RQ5 RQ6
      endcase
   endfunction

   // Same at channel width; upper bits dropped
   function automatic logic [`DCC_NUM_CHAN-1:0] apply_ch(
      input logic [`DCC_NUM_CHAN-1:0] old,
      input logic [`DCC_NUM_CHAN-1:0] wd,
      input access_type               acc);
      unique case (acc)
         ACC_SET:   apply_ch = old | wd;   // see RQ3
         ACC_CLEAR: apply_ch = old & ~wd;  // see RQ4
         default:   apply_ch = wd;         // see RQ2
      endcase
   endfunction

   // Channel is enabled; out-of-range selector counts as free
   function automatic logic ch_locked(
      input logic [`SEL_CHAN_HI-`SEL_CHAN_LO:0] ch,
      input logic [`DCC_NUM_CHAN-1:0]           en);
      ch_locked = 1'b0;
      for (int i = 0; i < `DCC_NUM_CHAN; i++) begin
         if (ch == (`SEL_CHAN_HI-`SEL_CHAN_LO+1)'(i)) begin
            ch_locked = en[i];
         end
      end
   endfunction

   assign wbits       = req.wdata[`DCC_NUM_CHAN-1:0];
   assign ring_ch     = s_r.ring_sel[`SEL_CHAN_HI:`SEL_CHAN_LO];
   assign algo_ch     = s_r.algo_sel[`SEL_CHAN_HI:`SEL_CHAN_LO];
   assign ring_locked = ch_locked(ring_ch, s_r.run_en);
   assign algo_locked = ch_locked(algo_ch, s_r.run_en);
   assign wr_hit      = ce & req.wr;
   assign rd_hit      = ce & req.rd;

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      s_nxt           = s_r;
      s_nxt.rst_pulse = `RST_CHAN;      // Command lasts one cycle
      s_nxt.ring_wr   = 1'b0;
      s_nxt.algo_wr   = 1'b0;
      s_nxt.rvalid    = rd_hit;
      // Register writes; run request held apart from the live enable
      if (req.wr) begin
         unique case (req.addr)
            `OFF_IRQ_EN: begin
               s_nxt.irq_en = apply32(s_r.irq_en, req.wdata, req.acc);  // see RQ11
            end
            `OFF_RUN_EN: begin
               // Software request; the live enable follows below
               s_nxt.run_req = apply_ch(s_r.run_req, wbits, req.acc);  // see RQ7 RQ2
            end
            `OFF_RST_CMD: begin
               // Enabled channels ignore the command
               s_nxt.rst_pulse = apply_ch(`RST_CHAN, wbits, req.acc) & ~s_r.run_en; // see RQ9 RQ10
            end
            `OFF_OVR_WIPE: begin
               s_nxt.overrun = s_r.overrun & ~wbits;  // see RQ19
            end
            `OFF_RING_SEL: begin
               s_nxt.ring_sel = apply32(s_r.ring_sel, req.wdata, req.acc);  // see RQ14
            end
            `OFF_RING_VAL: begin
               s_nxt.param_wdata = req.wdata;
               s_nxt.ring_wr     = !ring_locked;     // see RQ14 RQ17
            end
            `OFF_ALGO_SEL: begin
               s_nxt.algo_sel = apply32(s_r.algo_sel, req.wdata, req.acc);  // see RQ15
            end
            `OFF_ALGO_VAL: begin
               s_nxt.param_wdata = req.wdata;
               s_nxt.algo_wr     = !algo_locked;     // see RQ15 RQ17
            end
            `OFF_RAW_SRC: begin
               s_nxt.raw_src = apply32(s_r.raw_src, req.wdata, req.acc);    // see RQ16
            end
            `OFF_DECIM: begin
               s_nxt.decim = apply32(s_r.decim, req.wdata, req.acc);        // see RQ16
            end
            default: begin
               // Reserved and unmapped offsets ignore writes
            end                                                             // see RQ20
         endcase
      end
      // New overrun events win over a wipe
      s_nxt.overrun = s_nxt.overrun | stat.overrun_evt;                     // see RQ19
      // Live enable: request, or still busy after a drop request
      s_nxt.run_en = s_nxt.run_req | (s_r.run_en & stat.busy);             // see RQ7 RQ8 RQ18
      // Read mux, zero-filled above register width
      unique case (req.addr)
         `OFF_IRQ_EN:   s_nxt.rdata = s_r.irq_en;
         `OFF_RUN_EN:   s_nxt.rdata = {18'h0, s_r.run_en};                  // see RQ1 RQ18
         `OFF_THRESH:   s_nxt.rdata = {18'h0, stat.thresh};                 // see RQ12
         `OFF_DRAINED:  s_nxt.rdata = {18'h0, stat.drained};                // see RQ12
         `OFF_LOST:     s_nxt.rdata = {18'h0, stat.lost};                   // see RQ13
         `OFF_OVERRUN:  s_nxt.rdata = {18'h0, s_r.overrun};                 // see RQ13
         `OFF_RING_SEL: s_nxt.rdata = s_r.ring_sel;
         `OFF_RING_VAL: s_nxt.rdata = ring_rdata;
         `OFF_ALGO_SEL: s_nxt.rdata = s_r.algo_sel;
         `OFF_ALGO_VAL: s_nxt.rdata = algo_rdata;
         `OFF_RAW_SRC:  s_nxt.rdata = s_r.raw_src;
         `OFF_DECIM:    s_nxt.rdata = s_r.decim;
         default:       s_nxt.rdata = `RST_WORD;                            // see RQ1 RQ20
      endcase
      if (!req.rd) begin
         s_nxt.rdata = s_r.rdata;       // Hold last answer
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register, frozen while ce is low and rst_n is high
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_r <= '0;                     // see RQ7
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from state
   assign rdata       = s_r.rdata;
   assign rvalid      = s_r.rvalid;
   assign chan_en     = s_r.run_en;
   assign chan_reset  = s_r.rst_pulse;
   assign irq_en      = s_r.irq_en;
   assign ring_sel    = s_r.ring_sel;
   assign algo_sel    = s_r.algo_sel;
   assign param_wdata = s_r.param_wdata;
   assign ring_wr     = s_r.ring_wr;
   assign algo_wr     = s_r.algo_wr;
   assign raw_src     = s_r.raw_src;
   assign decim       = s_r.decim;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_enable_read_pad: assert property ( // see RQ1
      rd_hit && req.addr == `OFF_RUN_EN |=> rvalid && rdata[31:14] == 18'h0)
      else $error("enable read not zero padded");
   a_set_port_or: assert property ( // see RQ3
      wr_hit && req.addr == `OFF_IRQ_EN && req.acc == ACC_SET
      |=> irq_en == ($past(irq_en) | $past(req.wdata)))
      else $error("set access not OR");
   a_clear_port_and: assert property ( // see RQ4
      wr_hit && req.addr == `OFF_DECIM && req.acc == ACC_CLEAR
      |=> decim == ($past(decim) & ~$past(req.wdata)))
      else $error("clear access not AND NOT");
   a_plain_write_raw: assert property ( // see RQ2 RQ16
      wr_hit && req.addr == `OFF_RAW_SRC && req.acc == ACC_WRITE |=> raw_src == $past(req.wdata))
      else $error("raw source write lost");
   a_enable_ones_now: assert property ( // see RQ7
      wr_hit && req.addr == `OFF_RUN_EN && req.acc == ACC_WRITE
      |=> (chan_en & $past(wbits)) == $past(wbits))
      else $error("enable not immediate");
   a_busy_stays_on: assert property ( // see RQ8 RQ18
      ce && (chan_en & stat.busy) != '0 |=> (chan_en & $past(chan_en & stat.busy)) == $past(chan_en & stat.busy))
      else $error("busy channel disabled");
   a_reset_when_off: assert property ( // see RQ10
      wr_hit && req.addr == `OFF_RST_CMD && req.acc != ACC_CLEAR
      |=> chan_reset == ($past(wbits) & ~$past(chan_en))
      ##1 (chan_reset == '0 || !$past(ce) || $past(wr_hit && req.addr == `OFF_RST_CMD)))
      else $error("reset command wrong");
   a_overrun_wipe: assert property ( // see RQ19
      wr_hit && req.addr == `OFF_OVR_WIPE && stat.overrun_evt == '0 |=> (s_r.overrun & $past(wbits)) == '0)
      else $error("overrun wipe failed");
   a_overrun_set_wins: assert property ( // see RQ13 RQ19
      ce && stat.overrun_evt != '0 |=> (s_r.overrun & $past(stat.overrun_evt)) == $past(stat.overrun_evt))
      else $error("overrun event lost");
   a_reserved_reads: assert property ( // see RQ20
      rd_hit && (req.addr == `OFF_RSVD0 || req.addr == `OFF_RSVD1) |=> rdata == `RST_WORD)
      else $error("reserved read not zero");
   a_param_lock: assert property ( // see RQ17
      wr_hit && req.addr == `OFF_RING_VAL && ring_locked |=> !ring_wr)
      else $error("parameter written while enabled");
   a_enable_holds: assert property ( // see RQ7
      ce && !(wr_hit && req.addr == `OFF_RUN_EN)
      |=> (chan_en & $past(s_r.run_req)) == $past(s_r.run_req))
      else $error("idle enabled channel dropped");
endmodule

// [shared/dcc_regs_consts.svh]
// Offsets, widths and reset values of the channel control register bank.
// Assumes byte offsets on an 8-bit register address, one 32-bit word per register.
`ifndef DCC_REGS_CONSTS_SVH
`define DCC_REGS_CONSTS_SVH
`define DCC_NUM_CHAN    14
`define DCC_ADDR_W      8
`define DCC_DATA_W      32
`define OFF_IRQ_EN      8'h98
`define OFF_RUN_EN      8'h9c
`define OFF_RST_CMD     8'ha0
`define OFF_OVR_WIPE    8'ha4
`define OFF_THRESH      8'ha8
`define OFF_DRAINED     8'hac
`define OFF_LOST        8'hb0
`define OFF_OVERRUN     8'hb4
`define OFF_RSVD0       8'hb8
`define OFF_RSVD1       8'hbc
`define OFF_RING_SEL    8'hc0
`define OFF_RING_VAL    8'hc4
`define OFF_ALGO_SEL    8'hd0
`define OFF_ALGO_VAL    8'hd4
`define OFF_RAW_SRC     8'hd8
`define OFF_DECIM       8'hdc
`define SEL_CHAN_HI     31
`define SEL_CHAN_LO     16
`define RST_WORD        32'h0000_0000
`define RST_CHAN        14'h0000
`endif

// [shared/dcc_regs_pkg.sv]
// Types shared by the channel control register bank and its users.
// Assumes dcc_regs_consts.svh is on the include path.
`include "dcc_regs_consts.svh"
package dcc_regs_pkg;
   // Kind of register write
   typedef enum logic [1:0] {
      ACC_WRITE = 2'h0,
      ACC_SET   = 2'h1,
      ACC_CLEAR = 2'h2
   } access_type;
   // One register request
   typedef struct packed {
      logic                    wr;
      logic                    rd;
      access_type              acc;
      logic [`DCC_ADDR_W-1:0]  addr;
      logic [`DCC_DATA_W-1:0]  wdata;
   } reg_req_type;
   // Status reported by the channel controllers
   typedef struct packed {
      logic [`DCC_NUM_CHAN-1:0] busy;
      logic [`DCC_NUM_CHAN-1:0] thresh;
      logic [`DCC_NUM_CHAN-1:0] drained;
      logic [`DCC_NUM_CHAN-1:0] lost;
      logic [`DCC_NUM_CHAN-1:0] overrun_evt;
   } chan_stat_type;
   // Whole state of the register bank
   typedef struct packed {
      logic [`DCC_DATA_W-1:0]   irq_en;
      logic [`DCC_NUM_CHAN-1:0] run_en;
      logic [`DCC_NUM_CHAN-1:0] run_req;
      logic [`DCC_NUM_CHAN-1:0] rst_pulse;
      logic [`DCC_NUM_CHAN-1:0] overrun;
      logic [`DCC_DATA_W-1:0]   ring_sel;
      logic [`DCC_DATA_W-1:0]   algo_sel;
      logic [`DCC_DATA_W-1:0]   raw_src;
      logic [`DCC_DATA_W-1:0]   decim;
      logic [`DCC_DATA_W-1:0]   param_wdata;
      logic                     ring_wr;
      logic                     algo_wr;
      logic [`DCC_DATA_W-1:0]   rdata;
      logic                     rvalid;
   } state_type;
endpackage

// [bench/data_channel_control_regs_tb.sv]
// Self-checking bench for the channel control register bank: random and corner register traffic.
// Assumes dcc_regs_pkg and dcc_regs_consts.svh are compiled and on the include path first.
`timescale 1ns/1ns
`include "dcc_regs_consts.svh"
module data_channel_control_regs_tb;
   import dcc_regs_pkg::*;
   logic          core_clk   = 1'b0;   // 250 MHz core clock
   logic          rst_n      = 1'b0;   // Active-low reset
   logic          ce         = 1'b1;   // Clock enable
   reg_req_type   req        = '0;     // Register request
   chan_stat_type stat       = '0;     // Channel status inputs
   logic [31:0]   ring_rdata = 32'h0;  // Ring parameter read path
   logic [31:0]   algo_rdata = 32'h0;  // Algorithm parameter read path
   logic [31:0]   rdata, irq_en, ring_sel, algo_sel, param_wdata, raw_src, decim;
   logic          rvalid, ring_wr, algo_wr;
   logic [13:0]   chan_en, chan_reset, ovr;
   logic [13:0]   rst_seen = '0;       // Reset pulses collected per channel
   int            wcnt[2] = '{0, 0};   // Ring and algorithm write pulses
   int            mismatches = 0, checks_done = 0, cycles = 0, k, j, n;
   logic [1:0]    a;
   logic [31:0]   model[5], got, wd;
   logic [7:0]    offs[5] = '{8'h98, 8'hc0, 8'hd0, 8'hd8, 8'hdc};
   logic [7:0]    ro[8]   = '{8'ha8, 8'hac, 8'hb0, 8'hb4, 8'hb8, 8'hbc, 8'he0, 8'h00};
   ////////////////////////////////////////////////////////////////////////////////
   always #2 core_clk = ~core_clk;
   data_channel_control_regs dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .req(req), .rdata(rdata),
      .rvalid(rvalid), .stat(stat), .chan_en(chan_en), .chan_reset(chan_reset), .irq_en(irq_en),
      .ring_sel(ring_sel), .algo_sel(algo_sel), .param_wdata(param_wdata), .ring_wr(ring_wr),
      .algo_wr(algo_wr), .ring_rdata(ring_rdata), .algo_rdata(algo_rdata), .raw_src(raw_src), .decim(decim));
   // Pulse collection and hang guard
   always @(posedge core_clk) begin
      if (rst_n) rst_seen <= rst_seen | chan_reset;
      if (ring_wr === 1'b1) wcnt[0] <= wcnt[0] + 1;
      if (algo_wr === 1'b1) wcnt[1] <= wcnt[1] + 1;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         complete_run;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Expected value of a plain, set or clear write
   function automatic logic [31:0] apply(input logic [31:0] old, input logic [31:0] w, input logic [1:0] m);
      case (m)
         2'h1: return old | w;
         2'h2: return old & ~w;
         default: return w;
      endcase
   endfunction
   // Expected read of status, reserved and unmapped places
   function automatic logic [31:0] ro_exp(input logic [7:0] ad);
      case (ad)
         8'ha8: return {18'h0, stat.thresh};
         8'hac: return {18'h0, stat.drained};
         8'hb0: return {18'h0, stat.lost};
         8'hb4: return {18'h0, ovr};
         default: return 32'h0;
      endcase
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
      checks_done++;
      if (seen !== want) begin
         mismatches++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, want);
      end
   endtask
   // One request, held for one rising edge whether or not ce is high; reads wait a bounded time for rvalid
   task automatic bus(input logic w, input logic r, input logic [1:0] m, input logic [7:0] ad,
                      input logic [31:0] d);
      @(posedge core_clk);
      req <= '{wr: w, rd: r, acc: access_type'(m), addr: ad, wdata: d};
      @(posedge core_clk);
      req <= '0;
      got = 'x;
      for (int i = 0; i < 4 && r; i++) begin
         #1;
         if (rvalid === 1'b1) begin
            got = rdata;
            break;
         end
         @(posedge core_clk);
      end
   endtask
   task automatic rchk(input logic [7:0] ad, input logic [31:0] want, input string what);
      bus(1'b0, 1'b1, 2'h0, ad, 32'h0);
      check(got, want, what);
   endtask
   task automatic wait_edges(input int c);
      repeat (c) @(posedge core_clk);
      #1;
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      wd = $urandom(66);
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      // Reset values
      foreach (offs[i]) rchk(offs[i], 32'h0, "reset value");
      rchk(8'h9c, 32'h0, "enable reset");
      // Random plain, set and clear traffic on full-width registers
      foreach (model[i]) model[i] = 32'h0;
      repeat (40) begin
         k = $urandom_range(4);
         a = 2'($urandom_range(2));
         wd = $urandom;
         model[k] = apply(model[k], wd, a);
         bus(1'b1, 1'b0, a, offs[k], wd);
         rchk(offs[k], model[k], "read back");
      end
      // Signed fractional word passes bit for bit
      model[4] = 32'hffff_8000;
      bus(1'b1, 1'b0, 2'h0, 8'hdc, model[4]);
      rchk(8'hdc, model[4], "signed field");
      check(irq_en, model[0], "irq enable out");
      check(ring_sel, model[1], "ring selector out");
      check(algo_sel, model[2], "algo selector out");
      check(raw_src, model[3], "raw source out");
      check(decim, model[4], "decimation out");
      // Frozen clock enable drops a write
      @(posedge core_clk) ce <= 1'b0;
      bus(1'b1, 1'b0, 2'h0, 8'h98, ~model[0]);
      @(posedge core_clk) ce <= 1'b1;
      rchk(8'h98, model[0], "ce low write");
      // Live status, sticky overrun, partial wipe, writes to read-only places
      @(posedge core_clk);
      stat.thresh <= 14'($urandom);
      stat.drained <= 14'($urandom);
      stat.lost <= 14'($urandom);
      ovr = 14'($urandom) | 14'h0001;
      stat.overrun_evt <= ovr;
      @(posedge core_clk) stat.overrun_evt <= '0;
      wd = $urandom;
      bus(1'b1, 1'b0, 2'h0, 8'ha4, wd);
      ovr = ovr & ~wd[13:0];
      foreach (ro[i]) bus(1'b1, 1'b0, 2'h0, ro[i], 32'hffff_ffff);
      foreach (ro[i]) rchk(ro[i], ro_exp(ro[i]), "status read");
      // Idle enabled channel keeps running; 14-bit width and clear port
      bus(1'b1, 1'b0, 2'h0, 8'h9c, 32'hffff_e000);
      wait_edges(5);
      check({18'h0, chan_en}, 32'h0000_2000, "idle enable");
      rchk(8'h9c, 32'h0000_2000, "enable width");
      bus(1'b1, 1'b0, 2'h2, 8'h9c, 32'hffff_ffff);
      wait_edges(3);
      check({18'h0, chan_en}, 32'h0, "clear port");
      // Disable deferred while busy; reset refused while enabled
      @(posedge core_clk) stat.busy <= 14'h0001;
      bus(1'b1, 1'b0, 2'h0, 8'h9c, 32'h0000_0001);
      bus(1'b1, 1'b0, 2'h0, 8'ha0, 32'h0000_0001);
      bus(1'b1, 1'b0, 2'h0, 8'h9c, 32'h0);
      wait_edges(5);
      check({18'h0, chan_en}, 32'h1, "deferred disable");
      rchk(8'h9c, 32'h1, "enable while busy");
      check({18'h0, rst_seen}, 32'h0, "reset while enabled");
      @(posedge core_clk) stat.busy <= '0;
      wait_edges(3);
      check({18'h0, chan_en}, 32'h0, "disable after busy");
      rchk(8'h9c, 32'h0, "enable after busy");
      // Reset command on disabled channels, high bits dropped
      bus(1'b1, 1'b0, 2'h0, 8'ha0, 32'h0000_4003);
      wait_edges(3);
      check({18'h0, rst_seen}, 32'h0000_0003, "reset pulses");
      // Indirect parameter paths, free and locked
      @(posedge core_clk);
      ring_rdata <= $urandom;
      algo_rdata <= $urandom;
      for (j = 0; j < 2; j++) begin
         bus(1'b1, 1'b0, 2'h0, j ? 8'hd0 : 8'hc0, 32'h0003_0005);
         n = wcnt[j];
         wd = $urandom;
         bus(1'b1, 1'b0, 2'h0, j ? 8'hd4 : 8'hc4, wd);
         wait_edges(2);
         check(32'(wcnt[j] - n), 32'h1, "value write pulse");
         check(param_wdata, wd, "value write data");
         rchk(j ? 8'hd4 : 8'hc4, j ? algo_rdata : ring_rdata, "value read");
         @(posedge core_clk) stat.busy <= 14'h0008;
         bus(1'b1, 1'b0, 2'h0, 8'h9c, 32'h0000_0008);
         n = wcnt[j];
         bus(1'b1, 1'b0, 2'h0, j ? 8'hd4 : 8'hc4, ~wd);
         wait_edges(2);
         check(32'(wcnt[j] - n), 32'h0, "locked value write");
         @(posedge core_clk) stat.busy <= '0;
         bus(1'b1, 1'b0, 2'h0, 8'h9c, 32'h0);
         wait_edges(3);
      end
      complete_run;
   end
endmodule
